// ===== common/rtctod_pkg.sv
package rtctod_pkg;

    // I/O addresses of the count registers
    localparam logic [7:0] MINUTE_COUNT_ADDR       = 8'hE1;
    localparam logic [7:0] HOUR_COUNT_ADDR         = 8'hE2;
    localparam logic [7:0] WEEKDAY_COUNT_ADDR      = 8'hE3;
    localparam logic [7:0] CALENDAR_DAY_COUNT_ADDR = 8'hE4;

    // Field layout
    localparam int         TENS_DIGIT_LSB     = 4;
    localparam int         ONES_DIGIT_LSB     = 0;
    localparam logic [7:0] FULL_WRITE_MASK    = 8'hFF;
    localparam logic [7:0] WEEKDAY_VALUE_MASK = 8'h0F;

    // Ranges, as binary values
    localparam logic [7:0] MINUTE_FIRST  = 8'h00;
    localparam logic [7:0] MINUTE_LAST   = 8'h3B;
    localparam logic [7:0] HOUR_FIRST    = 8'h00;
    localparam logic [7:0] HOUR_LAST     = 8'h17;
    localparam logic [7:0] WEEKDAY_FIRST = 8'h01;
    localparam logic [7:0] WEEKDAY_LAST  = 8'h07;
    localparam logic [7:0] DAY_FIRST     = 8'h01;
    localparam logic [7:0] DAY_LAST      = 8'h1F;

    // Reset value of read data, and value read at unmapped addresses
    localparam logic [7:0] READ_DATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // Binary value 0..99 to two decimal digits
    function automatic logic [7:0] bin_to_bcd(input logic [7:0] bin);
        logic [7:0] tens;
        logic [7:0] ones;
        tens = bin / 8'h0A;
        ones = bin - 8'(tens * 8'h0A);
        return {tens[3:0], ones[3:0]};
    endfunction : bin_to_bcd

    // Next value of a two-digit decimal count
    function automatic logic [7:0] bcd_inc(input logic [7:0] code);
        logic [3:0] tens;
        logic [3:0] ones;
        tens = code[7:4];
        ones = code[3:0];
        if (ones == 4'h9)
            return {4'(tens + 4'h1), 4'h0};
        return {tens, 4'(ones + 4'h1)};
    endfunction : bcd_inc

endpackage : rtctod_pkg

// ===== common/rtctod_cnt_if.sv
`timescale 1ns/1ps
interface rtctod_cnt_if;
    logic       tick;
    logic       wr_en;
    logic [7:0] wr_data;
    logic       bcd_en;
    logic [7:0] value;
    logic       carry;

    modport unit (input tick, input wr_en, input wr_data, input bcd_en,
                  output value, output carry);
    modport ctrl (output tick, output wr_en, output wr_data, output bcd_en,
                  input value, input carry);
endinterface : rtctod_cnt_if

// ===== logic/rtctod_counter.sv
`timescale 1ns/1ps
module rtctod_counter #(
    parameter logic [7:0] FIRST_VAL = 8'h00,
    parameter logic [7:0] LAST_VAL  = 8'h3B,
    parameter logic [7:0] WR_MASK   = 8'hFF
) (
    // Clock
    input wire logic        sys_clk,
    // Count channel
    rtctod_cnt_if.unit      cnt
);

    logic [7:0] count;

    wire logic [7:0] last_code  = cnt.bcd_en ? rtctod_pkg::bin_to_bcd(LAST_VAL) : LAST_VAL;
    wire logic [7:0] first_code = cnt.bcd_en ? rtctod_pkg::bin_to_bcd(FIRST_VAL) : FIRST_VAL;
    wire logic       at_last    = (count == last_code);
    wire logic [7:0] inc_code   = cnt.bcd_en ? rtctod_pkg::bcd_inc(count) : 8'(count + 8'h01);
    wire logic [7:0] wrap_code  = at_last ? first_code : inc_code;
    wire logic [7:0] next_count = cnt.wr_en ? (cnt.wr_data & WR_MASK)
                                : cnt.tick  ? wrap_code
                                : count;

    // Count survives reset, so no reset term here
    always_ff @(posedge sys_clk)
    begin
        count <= next_count;
    end

    assign cnt.value = count;
    assign cnt.carry = cnt.tick & at_last;

endmodule : rtctod_counter

// ===== logic/rtctod_top.sv
// Summary of operation
// - Decimal minutes: tens digit bits 7:4 is 0-5, ones digit 0-9.
// - Binary minutes: full byte counts 0 to 59.
// - Decimal hours: tens digit 0-2 in bits 7:4, ones below, 24-hour.
// - Binary hours: full byte counts 0 to 23.
// - Weekday in bits 3:0, counts 1 to 7, same code both modes.
// - Weekday bits 7:4 are read-only and always read zero.
// - Decimal day: tens digit 0-3 in bits 7:4, ones 0-9.
// - Binary day: full byte counts 1 to 31.
// - Reset leaves minute, hour, weekday and day counts unchanged.
// - Locked: count writes ignored, reads allowed; unlocked: read and write.
// - Coding select 0 gives binary values, 1 gives two decimal digits.
// - Unlock 1 stops counting and allows writes; 0 counts; reset locks.
`timescale 1ns/1ps
module rtctod_top (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // I/O register bus
    input  wire logic [7:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_wdata,
    output logic      [7:0] io_rdata,
    // Control settings
    input  wire logic       count_unlock,
    input  wire logic       bcd_select,
    // Time base
    input  wire logic       second_wrap,
    // Status
    output logic            day_wrap,
    output logic            write_refused,
    output logic            counting
);

    // One count channel per register; each counter owns its value and carry
    rtctod_cnt_if minute_ch ();
    rtctod_cnt_if hour_ch ();
    rtctod_cnt_if weekday_ch ();
    rtctod_cnt_if day_ch ();

    // Lock state, held locked while reset is asserted. A change on the
    // control input takes effect one clock later, so a write in the same
    // cycle as the unlock is still refused.
    logic      unlocked;
    wire logic next_unlocked = count_unlock;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            unlocked <= 1'b0;
        else
            unlocked <= next_unlocked;
    end

    // Register address match, shared by the four count decodes
    function automatic logic addr_match(input logic [7:0] addr, input logic [7:0] target);
        return (addr == target);
    endfunction : addr_match

    // Address decode
    wire logic sel_minute  = addr_match(io_addr, rtctod_pkg::MINUTE_COUNT_ADDR);
    wire logic sel_hour    = addr_match(io_addr, rtctod_pkg::HOUR_COUNT_ADDR);
    wire logic sel_weekday = addr_match(io_addr, rtctod_pkg::WEEKDAY_COUNT_ADDR);
    wire logic sel_day     = addr_match(io_addr, rtctod_pkg::CALENDAR_DAY_COUNT_ADDR);
    wire logic sel_any     = sel_minute | sel_hour | sel_weekday | sel_day;

    // Writes only while unlocked; refusal is flagged only for the
    // four count addresses
    wire logic wr_open     = io_wr & unlocked & ~sys_rst;
    wire logic wr_blocked  = io_wr & sel_any & (~unlocked | sys_rst);

    wire logic wr_minute   = wr_open & sel_minute;
    wire logic wr_hour     = wr_open & sel_hour;
    wire logic wr_weekday  = wr_open & sel_weekday;
    wire logic wr_day      = wr_open & sel_day;

    wire logic count_run   = ~unlocked & ~sys_rst;
    wire logic base_tick   = second_wrap & count_run;

    // Coding select shared by every count; a change applies at once
    // and does not convert stored values
    wire logic coding_bcd  = bcd_select;

    // Carry chain: minutes to hours to weekday and day. The carries
    // ripple combinationally, so a full wrap settles on the tick's own edge.
    wire logic minute_carry = minute_ch.carry;
    wire logic hour_carry   = hour_ch.carry;

    assign minute_ch.tick    = base_tick;
    assign minute_ch.wr_en   = wr_minute;
    assign minute_ch.wr_data = io_wdata;
    assign minute_ch.bcd_en  = coding_bcd;

    assign hour_ch.tick      = minute_carry;
    assign hour_ch.wr_en     = wr_hour;
    assign hour_ch.wr_data   = io_wdata;
    assign hour_ch.bcd_en    = coding_bcd;

    // Weekday and day both advance on the hour carry
    assign weekday_ch.tick    = hour_carry;
    assign weekday_ch.wr_en   = wr_weekday;
    assign weekday_ch.wr_data = io_wdata;
    assign weekday_ch.bcd_en  = coding_bcd;

    assign day_ch.tick       = hour_carry;
    assign day_ch.wr_en      = wr_day;
    assign day_ch.wr_data    = io_wdata;
    assign day_ch.bcd_en     = coding_bcd;

    // Minutes wrap 59 to 0 in either coding
    // Wrap is an exact match, so a written out-of-range value counts onward
    rtctod_counter #(
        .FIRST_VAL (rtctod_pkg::MINUTE_FIRST),
        .LAST_VAL  (rtctod_pkg::MINUTE_LAST),
        .WR_MASK   (rtctod_pkg::FULL_WRITE_MASK)
    ) u_minute (
        .sys_clk (sys_clk),
        .cnt     (minute_ch)
    );

    // Hours wrap 23 to 0
    // The hour carry marks midnight for the weekday and day counts
    rtctod_counter #(
        .FIRST_VAL (rtctod_pkg::HOUR_FIRST),
        .LAST_VAL  (rtctod_pkg::HOUR_LAST),
        .WR_MASK   (rtctod_pkg::FULL_WRITE_MASK)
    ) u_hour (
        .sys_clk (sys_clk),
        .cnt     (hour_ch)
    );

    // Weekday 1 to 7, upper nibble masked on write and on read
    // A write keeps only the low nibble; counting on from an out-of-range value can set the reserved bits
    rtctod_counter #(
        .FIRST_VAL (rtctod_pkg::WEEKDAY_FIRST),
        .LAST_VAL  (rtctod_pkg::WEEKDAY_LAST),
        .WR_MASK   (rtctod_pkg::WEEKDAY_VALUE_MASK)
    ) u_weekday (
        .sys_clk (sys_clk),
        .cnt     (weekday_ch)
    );

    // Day 1 to 31, month length handled downstream
    // Short months are cut by the month logic, which counts day_wrap pulses
    rtctod_counter #(
        .FIRST_VAL (rtctod_pkg::DAY_FIRST),
        .LAST_VAL  (rtctod_pkg::DAY_LAST),
        .WR_MASK   (rtctod_pkg::FULL_WRITE_MASK)
    ) u_day (
        .sys_clk (sys_clk),
        .cnt     (day_ch)
    );

    // Count flops have no reset, only the lock and the outputs below do. The time
    // of day therefore survives a reset; after power-up the counts are
    // undefined until software loads them.

    // Per-register read values, reserved weekday bits forced to zero
    wire logic [7:0] minute_read  = minute_ch.value;
    wire logic [7:0] hour_read    = hour_ch.value;
    wire logic [7:0] weekday_read = weekday_ch.value & rtctod_pkg::WEEKDAY_VALUE_MASK;
    wire logic [7:0] day_read     = day_ch.value;

    // Unmapped addresses read as zero
    wire logic [7:0] read_mux =
          sel_minute  ? minute_read
        : sel_hour    ? hour_read
        : sel_weekday ? weekday_read
        : sel_day     ? day_read
        : rtctod_pkg::UNMAPPED_READ;

    // Reads allowed in either lock state
    wire logic [7:0] next_io_rdata      = io_rd ? read_mux : io_rdata;
    wire logic       next_day_wrap      = day_ch.carry;
    wire logic       next_write_refused = wr_blocked;
    wire logic       next_counting      = count_run;

    // Read data, loaded only on a read strobe
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            io_rdata <= rtctod_pkg::READ_DATA_RESET;
        else
            io_rdata <= next_io_rdata;
    end

    // Day wrap pulse, set on the same edge as the day count wraps; the month
    // logic outside counts these pulses
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            day_wrap <= 1'b0;
        else
            day_wrap <= next_day_wrap;
    end

    // Refused write pulse, one cycle after a locked write
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            write_refused <= 1'b0;
        else
            write_refused <= next_write_refused;
    end

    // Counting status follows the lock state
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            counting <= 1'b0;
        else
            counting <= next_counting;
    end

endmodule : rtctod_top

// ===== test/rtctod_top_properties.sv
`timescale 1ns/1ps
module rtctod_top_properties (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // I/O register bus
    input wire logic [7:0] io_addr,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    // Control and time base
    input wire logic       count_unlock,
    input wire logic       bcd_select,
    input wire logic       second_wrap,
    // Status
    input wire logic       day_wrap,
    input wire logic       write_refused,
    input wire logic       counting
);
    wire logic mapped = io_addr >= rtctod_pkg::MINUTE_COUNT_ADDR
                     && io_addr <= rtctod_pkg::CALENDAR_DAY_COUNT_ADDR;
    wire logic wd_sel = io_addr == rtctod_pkg::WEEKDAY_COUNT_ADDR;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_refuse_locked: assert property (
        io_wr && mapped && !$past(count_unlock) && !$past(sys_rst) |=> write_refused)
        else $error("locked write not flagged");
    a_accept_unlocked: assert property (
        io_wr && mapped && $past(count_unlock) && !$past(sys_rst) |=> !write_refused)
        else $error("unlocked write flagged");
    a_weekday_high: assert property (io_rd && wd_sel |=> io_rdata[7:4] == 4'h0)
        else $error("weekday upper bits not zero");
    a_unmapped_zero: assert property (io_rd && !mapped |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data changed without read");
    a_counting_lock: assert property (
        !$past(sys_rst) && !$past(sys_rst, 2) && $stable(count_unlock)
        && $past(count_unlock, 2) == count_unlock |-> counting == !count_unlock)
        else $error("counting does not follow lock");
    a_day_wrap_pulse: assert property (day_wrap |=> !day_wrap)
        else $error("day wrap longer than one cycle");
    a_day_wrap_cause: assert property (day_wrap |-> $past(second_wrap))
        else $error("day wrap without tick");
    c_refused: cover property (write_refused);
    c_day_wrap: cover property (day_wrap);
    c_weekday_rd: cover property (io_rd && wd_sel);
    c_bcd_day_wrap: cover property (day_wrap && bcd_select);
endmodule : rtctod_top_properties

bind rtctod_top rtctod_top_properties i_rtctod_top_properties (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .count_unlock(count_unlock), .bcd_select(bcd_select),
    .second_wrap(second_wrap), .day_wrap(day_wrap), .write_refused(write_refused),
    .counting(counting));

// ===== test/rtctod_top_tb.sv
`timescale 1ns/1ps
module rtctod_top_tb;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  io_addr = 8'h00;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic        count_unlock = 1'b0;
    logic        bcd_select = 1'b0;
    logic        second_wrap = 1'b0;
    logic [7:0]  io_rdata;
    logic        day_wrap;
    logic        write_refused;
    logic        counting;
    int          num_errors = 0;
    int          checked = 0;
    logic [31:0] seed = 32'd34588;
    logic [7:0]  v;
    logic        b;
    always #5 sys_clk = ~sys_clk;
    rtctod_top i_rtctod_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .io_addr(io_addr),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .count_unlock(count_unlock), .bcd_select(bcd_select), .second_wrap(second_wrap),
        .day_wrap(day_wrap), .write_refused(write_refused), .counting(counting));
    function automatic logic [7:0] rnd(input logic [7:0] lim);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 8'(seed % lim);
    endfunction : rnd
    // Expected minute after one tick, no wrap
    function automatic logic [7:0] next_min(input logic [7:0] m, input logic d);
        if (d && m[3:0] == 4'h9)
            return {4'(m[7:4] + 4'h1), 4'h0};
        return m + 8'h01;
    endfunction : next_min
    task automatic print_verdict;
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL io_rdata expected %h seen %h", exp, got);
        end
    endtask : chk
    task automatic chk_flag(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_flag
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge sys_clk);
        io_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        @(negedge sys_clk);
        chk(exp, io_rdata);
    endtask : rd
    task automatic set_lock(input logic u);
        @(posedge sys_clk);
        count_unlock <= u;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk_flag("counting", ~u, counting);
    endtask : set_lock
    task automatic tick;
        @(posedge sys_clk);
        second_wrap <= 1'b1;
        @(posedge sys_clk);
        second_wrap <= 1'b0;
    endtask : tick
    task automatic rd4(input logic [31:0] w);
        for (int i = 0; i < 4; i++)
            rd(8'hE1 + 8'(i), w[31 - 8 * i -: 8]);
    endtask : rd4
    task automatic load(input logic [31:0] w);
        set_lock(1'b1);
        for (int i = 0; i < 4; i++)
            wr(8'hE1 + 8'(i), w[31 - 8 * i -: 8]);
        set_lock(1'b0);
    endtask : load
    initial
    begin
        #100000;
        num_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        set_lock(1'b1);
        v = rnd(8'h3C);
        wr(8'hE1, v);
        @(negedge sys_clk);
        chk_flag("write_refused", 1'b0, write_refused);
        tick();
        rd(8'hE1, v);
        wr(8'hE3, 8'hF5);
        rd(8'hE3, 8'h05);
        set_lock(1'b0);
        wr(8'hE1, v ^ 8'h01);
        @(negedge sys_clk);
        chk_flag("write_refused", 1'b1, write_refused);
        rd(8'hE1, v);
        load(32'h3B17071F);
        tick();
        @(negedge sys_clk);
        chk_flag("day_wrap", 1'b1, day_wrap);
        rd4(32'h00000101);
        @(posedge sys_clk);
        bcd_select <= 1'b1;
        load(32'h59230731);
        tick();
        rd4(32'h00000101);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd4(32'h00000101);
        rd(8'hE0, 8'h00);
        load(32'h59190329);
        tick();
        rd4(32'h00200329);
        load(32'h59230329);
        tick();
        rd4(32'h00000430);
        @(posedge sys_clk);
        bcd_select <= 1'b0;
        load(32'h3B09030F);
        tick();
        rd4(32'h000A030F);
        load(32'h3B17030F);
        tick();
        rd4(32'h00000410);
        for (int i = 0; i < 8; i++)
        begin
            b = seed[3];
            v = rnd(8'h3B);
            v = b ? 8'((v / 8'h0A) * 8'h10 + v % 8'h0A) : v;
            @(posedge sys_clk);
            bcd_select <= b;
            load({v, 24'h17071F});
            tick();
            @(negedge sys_clk);
            chk_flag("day_wrap", 1'b0, day_wrap);
            rd(8'hE1, next_min(v, b));
        end
        print_verdict();
    end
endmodule : rtctod_top_tb
